// file: verilog/trap_ctrl_pkg.sv
// package: addresses, bit positions, reset values and opcode constants for the
// undefined-opcode trap controller.
// assumes nothing of its surroundings.
package trap_ctrl_pkg;
  // ********************
  // register map
  // ********************
  localparam logic [7:0] TRAP_CTRL_ADDR = 8'h34;
  localparam int TRAP_FLAG_BIT = 7;
  localparam int FETCH_POS_BIT = 6;
  localparam int IRQ_TWO_EN_BIT = 2;
  localparam int IRQ_ONE_EN_BIT = 1;
  localparam int LEVEL_ZERO_EN_BIT = 0;
  localparam logic TRAP_FLAG_RESET = 1'b0;
  localparam logic FETCH_POS_RESET = 1'b0;
  localparam logic IRQ_TWO_EN_RESET = 1'b0;
  localparam logic IRQ_ONE_EN_RESET = 1'b0;
  localparam logic LEVEL_ZERO_EN_RESET = 1'b1;
  // ********************
  // prefix bytes and trap vector
  // ********************
  localparam logic [7:0] PREFIX_CB = 8'hCB;
  localparam logic [7:0] PREFIX_DD = 8'hDD;
  localparam logic [7:0] PREFIX_ED = 8'hED;
  localparam logic [7:0] PREFIX_FD = 8'hFD;
  localparam logic [15:0] TRAP_VECTOR = 16'h0000;
  // fetch position of the undefined byte
  localparam logic POS_SECOND = 1'b0;
  localparam logic POS_THIRD = 1'b1;
endpackage : trap_ctrl_pkg

// file: verilog/prefix_tracker.sv
// prefix_tracker: follows the opcode bytes of one instruction to tell which
// byte position is being fetched.
// assumes fetch strobes come from the core on mclk, one per opcode byte.
`timescale 1ns/1ps
`default_nettype none
module prefix_tracker
  import trap_ctrl_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // fetch stream
  input wire logic opc_fetch,
  input wire logic [7:0] opc_byte,
  input wire logic instr_start,
  // position of the next byte
  output logic in_second,
  output logic in_third
);
  typedef enum logic [1:0] {ST_FIRST, ST_SECOND, ST_DDFD, ST_THIRD} pos_t;
  pos_t pos_reg;
  // ********************
  // position tracking
  // ********************
  // displacement byte of DDCB/FDCB is not an opcode fetch, so the core does not strobe it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pos_reg <= ST_FIRST;
    end else if (instr_start) begin
      pos_reg <= ST_FIRST;
    end else if (opc_fetch) begin
      unique case (pos_reg)
        ST_FIRST: begin
          if (opc_byte == PREFIX_DD || opc_byte == PREFIX_FD) begin
            pos_reg <= ST_DDFD;
          end else if (opc_byte == PREFIX_CB || opc_byte == PREFIX_ED) begin
            pos_reg <= ST_SECOND;
          end else begin
            pos_reg <= ST_FIRST;
          end
        end
        ST_DDFD: begin
          if (opc_byte == PREFIX_CB) begin
            pos_reg <= ST_THIRD;
          end else begin
            pos_reg <= ST_FIRST;
          end
        end
        ST_SECOND: begin
          pos_reg <= ST_FIRST;
        end
        ST_THIRD: begin
          pos_reg <= ST_FIRST;
        end
      endcase
    end
  end
  assign in_second = (pos_reg == ST_SECOND) || (pos_reg == ST_DDFD);
  assign in_third = (pos_reg == ST_THIRD);
endmodule : prefix_tracker
`default_nettype wire

// file: verilog/irq_gate.sv
// irq_gate: passes the three maskable interrupt levels through their enables.
// assumes request inputs are already synchronised to mclk.
`timescale 1ns/1ps
`default_nettype none
module irq_gate (
  // requests
  input wire logic [2:0] req_in,
  // enables
  input wire logic [2:0] enable,
  // gated requests
  output logic [2:0] req_out
);
  // ********************
  // per-level gating
  // ********************
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_lvl
      assign req_out[g] = req_in[g] & enable[g];
    end
  endgenerate
endmodule : irq_gate
`default_nettype wire

// file: verilog/undefined_opcode_trap_ctrl.sv
// undefined_opcode_trap_ctrl: trap flag, fetch position and interrupt level
// enables behind internal I/O address 34h.
// assumes the core strobes opcode fetches and decode verdicts on mclk and
// accesses internal I/O with one-cycle read/write strobes.
`timescale 1ns/1ps
`default_nettype none
module undefined_opcode_trap_ctrl
  import trap_ctrl_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // internal I/O register access
  input wire logic [7:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  // fetch and decode from the core
  input wire logic opc_fetch,
  input wire logic ack_fetch_mode0,
  input wire logic [7:0] opc_byte,
  input wire logic opc_undefined,
  input wire logic instr_start,
  input wire logic [15:0] pc_now,
  input wire logic maskable_irq_enable_flipflop,
  // trap action to the core
  output logic trap_take,
  output logic [15:0] trap_push_pc,
  output logic [15:0] trap_vector_addr,
  // external interrupt pins, active low, with the on-chip level zero request and the gated level requests
  input wire logic ext_irq_zero_input_n,
  input wire logic ext_irq_one_input_n,
  input wire logic ext_irq_two_input_n,
  input wire logic level_zero_onchip_req,
  output logic [2:0] irq_level_req
);
  logic trap_flag_reg;
  logic fetch_position_indicator;
  logic ext_irq_two_enable;
  logic ext_irq_one_enable;
  logic level_zero_irq_enable;
  logic in_second;
  logic in_third;
  logic trap_event;
  logic reg_sel;
  logic [2:0] pin_s1_reg;
  logic [2:0] pin_s2_reg;
  logic [2:0] req_raw;
  logic [2:0] req_gated;

  // ********************
  // byte position
  // ********************
  prefix_tracker u_tracker (
    .mclk(mclk),
    .rst_n(rst_n),
    .opc_fetch(opc_fetch | ack_fetch_mode0),
    .opc_byte(opc_byte),
    .instr_start(instr_start),
    .in_second(in_second),
    .in_third(in_third)
  );

  // ********************
  // trap detection
  // ********************
  // enable flipflop unused
  assign trap_event = (opc_fetch | ack_fetch_mode0) & opc_undefined & (in_second | in_third);
  assign reg_sel = (io_addr == TRAP_CTRL_ADDR);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trap_flag_reg <= TRAP_FLAG_RESET;
    end else if (trap_event) begin
      trap_flag_reg <= 1'b1;
    end else if (io_wr && reg_sel && !io_wdata[TRAP_FLAG_BIT]) begin
      trap_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_position_indicator <= FETCH_POS_RESET;
    end else if (trap_event) begin
      fetch_position_indicator <= in_third ? POS_THIRD : POS_SECOND;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ext_irq_two_enable <= IRQ_TWO_EN_RESET;
      ext_irq_one_enable <= IRQ_ONE_EN_RESET;
      level_zero_irq_enable <= LEVEL_ZERO_EN_RESET;
    end else if (io_wr && reg_sel) begin
      ext_irq_two_enable <= io_wdata[IRQ_TWO_EN_BIT];
      ext_irq_one_enable <= io_wdata[IRQ_ONE_EN_BIT];
      level_zero_irq_enable <= io_wdata[LEVEL_ZERO_EN_BIT];
    end
  end

  // push current counter, vector to zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trap_take <= 1'b0;
      trap_push_pc <= 16'h0000;
      trap_vector_addr <= TRAP_VECTOR;
    end else begin
      trap_take <= trap_event;
      trap_vector_addr <= TRAP_VECTOR;
      if (trap_event) begin
        trap_push_pc <= pc_now;
      end
    end
  end

  // ********************
  // register read
  // ********************
  // unused bits zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata <= 8'h00;
    end else if (io_rd && reg_sel) begin
      io_rdata <= {trap_flag_reg, fetch_position_indicator, 3'b000,
                   ext_irq_two_enable, ext_irq_one_enable, level_zero_irq_enable};
    end else begin
      io_rdata <= 8'h00;
    end
  end

  // ********************
  // interrupt gating
  // ********************
  // pins are asynchronous, so two flops before use
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg <= 3'b000;
      pin_s2_reg <= 3'b000;
    end else begin
      pin_s1_reg <= {~ext_irq_two_input_n, ~ext_irq_one_input_n, ~ext_irq_zero_input_n};
      pin_s2_reg <= pin_s1_reg;
    end
  end
  assign req_raw = {pin_s2_reg[2], pin_s2_reg[1], pin_s2_reg[0] | level_zero_onchip_req};

  irq_gate u_gate (
    .req_in(req_raw),
    .enable({ext_irq_two_enable, ext_irq_one_enable, level_zero_irq_enable}),
    .req_out(req_gated)
  );

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_level_req <= 3'b000;
    end else begin
      irq_level_req <= req_gated;
    end
  end

  // ********************
  // checks
  // ********************
  AST_FLAG_SET: assert property (@(posedge mclk) disable iff (!rst_n)
    trap_event |=> trap_flag_reg) else $error("trap flag not set");
  AST_FLAG_CLEAR: assert property (@(posedge mclk) disable iff (!rst_n)
    (io_wr && reg_sel && !io_wdata[TRAP_FLAG_BIT] && !trap_event) |=> !trap_flag_reg)
    else $error("trap flag not cleared");
  AST_FLAG_NO_SW_SET: assert property (@(posedge mclk) disable iff (!rst_n)
    (!trap_flag_reg && !trap_event) |=> !trap_flag_reg) else $error("flag set without trap");
  AST_POS_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    !trap_event |=> $stable(fetch_position_indicator)) else $error("position changed");
  AST_POS_THIRD: assert property (@(posedge mclk) disable iff (!rst_n)
    (trap_event && in_third) |=> fetch_position_indicator) else $error("position not third");
  AST_GATE_TWO: assert property (@(posedge mclk) disable iff (!rst_n)
    !ext_irq_two_enable ##1 !ext_irq_two_enable |=> !irq_level_req[2])
    else $error("blocked input two passed");
  AST_GATE_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
    (level_zero_irq_enable && level_zero_onchip_req) |=> irq_level_req[0])
    else $error("level zero not passed");
  AST_UNMASKABLE: assert property (@(posedge mclk) disable iff (!rst_n)
    (trap_event && !maskable_irq_enable_flipflop) |=> trap_take) else $error("trap masked");
  AST_PUSH_PC: assert property (@(posedge mclk) disable iff (!rst_n)
    trap_event |=> (trap_take && trap_push_pc == $past(pc_now) && trap_vector_addr == 16'h0000))
    else $error("trap push or vector wrong");
  AST_READ_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
    (io_rd && reg_sel) |=> io_rdata[5:3] == 3'b000) else $error("unused bits nonzero");
  AST_FLAG_KEEP: assert property (@(posedge mclk) disable iff (!rst_n)
    (trap_flag_reg && io_wr && reg_sel && io_wdata[TRAP_FLAG_BIT]) |=> trap_flag_reg)
    else $error("writing one cleared the flag");
  AST_POS_SECOND: assert property (@(posedge mclk) disable iff (!rst_n)
    (trap_event && in_second) |=> !fetch_position_indicator) else $error("position not second");
  AST_FIRST_NO_TRAP: assert property (@(posedge mclk) disable iff (!rst_n)
    ((opc_fetch || ack_fetch_mode0) && opc_undefined && !in_second && !in_third) |=> !trap_take)
    else $error("first byte trapped");
endmodule : undefined_opcode_trap_ctrl
`default_nettype wire

// file: verification/core_model.sv
// core_model: stands in for the core's fetch and decode path.
// assumes it is called at falling edges of mclk from the bench's sequence.
`timescale 1ns/1ps
`default_nettype none
module core_model (
  // clock
  input wire logic mclk,
  // fetch stream to the trap controller
  output logic opc_fetch,
  output logic ack_fetch_mode0,
  output logic [7:0] opc_byte,
  output logic opc_undefined,
  output logic instr_start,
  output logic [15:0] pc_now
);
  initial begin
    opc_fetch = 1'b0;
    ack_fetch_mode0 = 1'b0;
    opc_byte = 8'h00;
    opc_undefined = 1'b0;
    instr_start = 1'b0;
    pc_now = 16'h0000;
  end
  // one instruction boundary, on a cycle of its own
  task start();
    instr_start = 1'b1;
    @(negedge mclk);
    instr_start = 1'b0;
  endtask : start
  // one opcode byte, held for a full cycle
  task fetch(input logic [7:0] b, input logic undef, input logic ack, input logic [15:0] pc);
    opc_fetch = ~ack;
    ack_fetch_mode0 = ack;
    opc_byte = b;
    opc_undefined = undef;
    pc_now = pc;
    @(negedge mclk);
  endtask : fetch
  // released lines show inverted data so stale values never pass
  task idle();
    opc_fetch = 1'b0;
    ack_fetch_mode0 = 1'b0;
    opc_byte = ~opc_byte;
    opc_undefined = ~opc_undefined;
    pc_now = ~pc_now;
  endtask : idle
endmodule : core_model
`default_nettype wire

// file: verification/undefined_opcode_trap_ctrl_bench.sv
// undefined_opcode_trap_ctrl_bench: register, trap and gating scenarios.
// assumes core_model drives the fetch side; inputs change at falling edges.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module undefined_opcode_trap_ctrl_bench;
  import trap_ctrl_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, io_wr = 1'b0, io_rd = 1'b0, mie_ff = 1'b0, onchip = 1'b0;
  logic [7:0] io_addr = 8'h00, io_wdata = 8'h00;
  logic [2:0] pins_n = 3'b111, en = 3'b001;
  wire logic [7:0] io_rdata, opc_byte;
  wire logic [15:0] push_pc, vec, pc_now;
  wire logic [2:0] irq_req;
  wire logic trap_take, opc_fetch, ack_f, opc_undef, instr_start;
  int errors = 0, checks_done = 0, cycles = 0;
  logic [7:0] pre [4] = '{PREFIX_CB, PREFIX_DD, PREFIX_ED, PREFIX_FD};
  always #25 mclk = ~mclk;
  core_model core_u (.mclk(mclk), .opc_fetch(opc_fetch), .ack_fetch_mode0(ack_f),
    .opc_byte(opc_byte), .opc_undefined(opc_undef), .instr_start(instr_start), .pc_now(pc_now));
  undefined_opcode_trap_ctrl dut_u (.mclk(mclk), .rst_n(rst_n), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .opc_fetch(opc_fetch), .ack_fetch_mode0(ack_f), .opc_byte(opc_byte),
    .opc_undefined(opc_undef), .instr_start(instr_start), .pc_now(pc_now),
    .maskable_irq_enable_flipflop(mie_ff), .trap_take(trap_take), .trap_push_pc(push_pc),
    .trap_vector_addr(vec), .ext_irq_zero_input_n(pins_n[0]), .ext_irq_one_input_n(pins_n[1]),
    .ext_irq_two_input_n(pins_n[2]), .level_zero_onchip_req(onchip), .irq_level_req(irq_req));
  // ********************
  // register access and closing
  // ********************
  task reg_wr(input logic [7:0] a, input logic [7:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge mclk);
    io_wr = 1'b0;
  endtask : reg_wr
  task reg_rd(input logic [7:0] a, input logic [7:0] exp);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge mclk);
    io_rd = 1'b0;
    `CHK(io_rdata, exp)
  endtask : reg_rd
  task tally_and_finish();
    if (errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  // bench time is tiny; the ceiling only catches a hang
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      tally_and_finish();
    end
  end
  // ********************
  // scenarios
  // ********************
  task reset_and_map();
    reg_rd(TRAP_CTRL_ADDR, 8'h01);
    reg_wr(8'h35, 8'hFF);
    reg_rd(TRAP_CTRL_ADDR, 8'h01);
    // read data stands one cycle only, then drops back to zero
    @(negedge mclk);
    `CHK(io_rdata, 8'h00)
    reg_rd(8'h35, 8'h00);
    reg_wr(TRAP_CTRL_ADDR, 8'hFF);
    en = 3'b111;
    reg_rd(TRAP_CTRL_ADDR, 8'h07);
  endtask : reset_and_map
  task trap_case(input logic [7:0] p1, input logic dbl, input logic ack, input logic [15:0] pc);
    core_u.start();
    core_u.fetch(p1, 1'b0, ack, pc - 16'h0001);
    if (dbl) core_u.fetch(PREFIX_CB, 1'b0, ack, pc - 16'h0001);
    core_u.fetch(8'h3F, 1'b1, ack, pc);
    `CHK(trap_take, 1'b1)
    `CHK(push_pc, pc)
    `CHK(vec, TRAP_VECTOR)
    core_u.idle();
    @(negedge mclk);
    `CHK(trap_take, 1'b0)
    reg_wr(TRAP_CTRL_ADDR, {1'b1, 4'hF, en});
    reg_rd(TRAP_CTRL_ADDR, {1'b1, dbl, 3'b000, en});
    reg_wr(TRAP_CTRL_ADDR, {5'h00, en});
    reg_rd(TRAP_CTRL_ADDR, {1'b0, dbl, 3'b000, en});
  endtask : trap_case
  task first_byte_no_trap();
    core_u.start();
    core_u.fetch(8'h3F, 1'b1, 1'b0, 16'h1234);
    core_u.idle();
    `CHK(trap_take, 1'b0)
    reg_rd(TRAP_CTRL_ADDR, {5'h00, en});
  endtask : first_byte_no_trap
  // mid-run reset must drop a set flag and restore the enables
  task reset_mid();
    core_u.start();
    core_u.fetch(PREFIX_CB, 1'b0, 1'b0, 16'h0010);
    core_u.fetch(8'h3F, 1'b1, 1'b0, 16'h0011);
    `CHK(trap_take, 1'b1)
    core_u.idle();
    rst_n = 1'b0;
    @(negedge mclk);
    `CHK(trap_take, 1'b0)
    `CHK(irq_req, 3'b000)
    rst_n = 1'b1;
    en = 3'b001;
    @(negedge mclk);
    reg_rd(TRAP_CTRL_ADDR, 8'h01);
  endtask : reset_mid
  // pins pass two synchroniser stages, so allow a few cycles
  task gate_case(input logic [2:0] e, input logic [2:0] p, input logic oc);
    reg_wr(TRAP_CTRL_ADDR, {5'h00, e});
    en = e;
    pins_n = p;
    onchip = oc;
    repeat (4) @(negedge mclk);
    `CHK(irq_req, e & {~p[2], ~p[1], ~p[0] | oc})
  endtask : gate_case
  initial begin
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    reset_and_map();
    for (int i = 0; i < 4; i++) trap_case(pre[i], 1'b0, i[0], 16'h2000 + 16'(i));
    trap_case(PREFIX_DD, 1'b1, 1'b0, 16'h4321);
    mie_ff = 1'b1;
    trap_case(PREFIX_FD, 1'b1, 1'b1, 16'hFFFE);
    // position must fall back to second byte on the next single-prefix trap
    trap_case(PREFIX_ED, 1'b0, 1'b0, 16'h0102);
    first_byte_no_trap();
    gate_case(3'b111, 3'b000, 1'b0);
    gate_case(3'b010, 3'b000, 1'b1);
    gate_case(3'b001, 3'b111, 1'b1);
    gate_case(3'b101, 3'b110, 1'b0);
    reset_mid();
    tally_and_finish();
  end
endmodule : undefined_opcode_trap_ctrl_bench
`default_nettype wire
